/* File: hdl/acq_consts.svh */
// constants for the acquisition mode controller
// Overview of operation
// - auto-zero enable accepts 1/ON to enable, 0/OFF to disable
// - method selector: normal, burst, text stream, count stream
// - normal method stores readings at the configured conversion pace
// - burst saves configuration, applies fastest, restores on normal
// - burst uses compact grouping, so no time-stamps
// - burst only for DCV, ACV, DCI, ACI, two-wire ohms
// - selecting burst enters idle with storing lamp off
// - after release, scan event starts storing; storing lamp lit
// - after storage, processing lamp lit during math, then idle
// - bus command other than an accepted method select during capture aborts, processes stored readings
// - streams send fresh readings as text or as counts
// - streaming only for DCV, ACV, DCI, ACI, two-wire ohms
// - sustain 1000 text or 2000 count readings per second
// - each talk addressing sends exactly one reading
// - count reading is two bytes, end flag on second
// - text reading ends with line feed plus end flag
// - stream ignores commands and locks front panel
// - device clear ends stream, streaming settings kept
`ifndef ACQ_CONSTS_SVH
`define ACQ_CONSTS_SVH
`define CLK_HZ_DEF     10000000
`define TEXT_RATE_DEF  1000
`define COUNT_RATE_DEF 2000
`define FIFO_DEPTH_DEF 8
`define RDG_W          16
`define CFG_W          8
`define CNT_W          16
`define PACE_W         24
`define AZ_RESET       1'b1
`define CFG_RESET      8'hFF
`define CFG_FAST       8'h00
`define CFG_STREAM_KEEP 8'h00
`define CH_PLUS        8'h2B
`define CH_MINUS       8'h2D
`define CH_ZERO        8'h30
`define CH_ONE         8'h31
`define CH_LF          8'h0A
`define NAME_NORM      32'h4E4F524D
`define NAME_BURS      32'h42555253
`define NAME_ASTR      32'h41535452
`define NAME_SSTR      32'h53535452
`define IDX_COUNT_LAST 3'h1
`define IDX_TEXT_LAST  3'h6
`endif

/* File: hdl/acq_pkg.sv */
// types shared by the acquisition mode controller
package acq_pkg;
    typedef enum logic [1:0] {METH_NORMAL, METH_BURST, METH_TEXT, METH_COUNT} method_t;
    typedef enum logic [3:0] {FN_DCV, FN_ACV, FN_DCI, FN_ACI, FN_RES2, FN_RES4,
                              FN_TEMP, FN_FREQ, FN_INCKT, FN_PEAK} func_t;
    typedef enum logic [2:0] {CMD_AUTOZERO, CMD_METHOD, CMD_INIT, CMD_CONT,
                              CMD_ABORT, CMD_CONFIG, CMD_OTHER} cmd_t;
    typedef enum logic [2:0] {M_IDLE, M_RUN, M_WAIT, M_STORE, M_PROC, M_STREAM} meas_t;
endpackage : acq_pkg

/* File: hdl/acquisition_mode_control.sv */
// acquisition method and auto-zero control with stream output
`timescale 1ns/1ps
`include "acq_consts.svh"
module acquisition_mode_control import acq_pkg::*; #(
    parameter int CLK_HZ        = `CLK_HZ_DEF,
    parameter int TEXT_RATE_HZ  = `TEXT_RATE_DEF,
    parameter int COUNT_RATE_HZ = `COUNT_RATE_DEF,
    parameter int FIFO_DEPTH    = `FIFO_DEPTH_DEF
)(
    input  wire logic               clk_sys,        // system clock
    input  wire logic               rst,            // sync reset
    input  wire logic               cmdValid,       // bus command strobe
    input  wire cmd_t               cmdCode,        // command kind
    input  wire logic               cmdFlag,        // boolean argument
    input  wire method_t            cmdMethod,      // method argument
    input  wire logic [`CFG_W-1:0]  cmdCfg,         // configuration argument
    input  wire logic               deviceClear,    // device clear pulse
    input  wire func_t              measFunc,       // present function
    input  wire logic               scanEvent,      // scan event pulse
    input  wire logic [`CNT_W-1:0]  bufSize,        // readings per burst
    input  wire logic               readingValid,   // fresh conversion
    input  wire logic [`RDG_W-1:0]  readingCount,   // signed counts
    input  wire logic               talkAddr,       // addressed to talk
    input  wire logic               txReady,        // byte taken
    output logic                    autoZeroEn_q,   // auto-zero enabled
    output method_t                 methodSel_q,    // acquisition method
    output logic [7:0]              azReply_q,      // auto-zero answer
    output logic [31:0]             methodName_q,   // method answer
    output logic [`CFG_W-1:0]       activeConfig_q, // applied config
    output logic                    compactGroup_q, // compact buffer layout
    output logic                    stampEnable_q,  // time-stamps kept
    output logic                    armLamp_q,      // storing indicator
    output logic                    procLamp_q,     // processing indicator
    output logic                    idle_q,         // measurement idle
    output logic                    storeWrite_q,   // buffer write pulse
    output logic [`RDG_W-1:0]       storeData_q,    // buffer write data
    output logic [`CNT_W-1:0]       storeCount_q,   // readings stored
    output logic                    mathStep_q,     // math on one entry
    output logic [`CNT_W-1:0]       mathAddr_q,     // entry under math
    output logic                    panelLock_q,    // front panel locked
    output logic                    convStart_q,    // conversion pace pulse
    output logic                    txValid_q,      // byte offered
    output logic [7:0]              txByte_q,       // byte value
    output logic                    txEoi_q         // end flag with byte
);
    localparam int TEXT_PERIOD  = CLK_HZ / TEXT_RATE_HZ;
    localparam int COUNT_PERIOD = CLK_HZ / COUNT_RATE_HZ;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    meas_t              measState_q;
    meas_t              measNext;
    logic               contArm_q;
    logic [`CFG_W-1:0]  savedConfig_q;
    logic [`PACE_W-1:0] paceCnt_q;
    logic               talkPend_q;
    logic               txBusy_q;
    logic [2:0]         txIdx_q;
    logic [`RDG_W-1:0]  txWord_q;

    fifo_if #(.W(`RDG_W)) ff ();

    reading_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys (clk_sys),
        .rst     (rst),
        .flush   (deviceClear),
        .port    (ff.store)
    );

    // command acceptance and decode
    wire inStream  = (measState_q == M_STREAM);
    wire cmdAccept = cmdValid && !inStream;
    wire isIdle    = (measState_q == M_IDLE);
    wire funcOk    = (measFunc == FN_DCV) || (measFunc == FN_ACV) || (measFunc == FN_DCI)
                     || (measFunc == FN_ACI) || (measFunc == FN_RES2);
    wire methOk    = (cmdMethod == METH_NORMAL) || funcOk;
    wire azWrite   = cmdAccept && (cmdCode == CMD_AUTOZERO) && isIdle;
    wire methWrite = cmdAccept && (cmdCode == CMD_METHOD) && methOk;
    wire toBurst   = methWrite && (cmdMethod == METH_BURST);
    wire toNormal  = methWrite && (cmdMethod == METH_NORMAL);
    wire toStream  = methWrite && ((cmdMethod == METH_TEXT) || (cmdMethod == METH_COUNT));
    wire initCmd   = cmdAccept && (cmdCode == CMD_INIT);
    wire contWrite = cmdAccept && (cmdCode == CMD_CONT);
    wire abortCmd  = cmdAccept && (cmdCode == CMD_ABORT);
    wire cfgWrite  = cmdAccept && (cmdCode == CMD_CONFIG) && (methodSel_q == METH_NORMAL);
    wire release_  = initCmd || contArm_q;
    wire storeFull = (storeCount_q == bufSize);
    wire procDone  = (mathAddr_q == storeCount_q);
    wire storing   = (measState_q == M_RUN) || (measState_q == M_STORE);

    // measurement sequence
    always_comb begin
        measNext = measState_q;
        unique case (measState_q)
            M_IDLE: begin
                if (initCmd || (contArm_q && !cmdValid))
                    measNext = (methodSel_q == METH_BURST) ? M_WAIT : M_RUN;
            end
            M_RUN: begin
                if (abortCmd || storeFull) measNext = M_IDLE;
            end
            M_WAIT: begin
                if (abortCmd) measNext = M_IDLE;
                else if (scanEvent) measNext = M_STORE;
            end
            M_STORE: begin
                if (cmdValid || storeFull) measNext = M_PROC;
            end
            M_PROC: begin
                if (procDone) measNext = M_IDLE;
            end
            M_STREAM: begin
                if (deviceClear) measNext = M_IDLE;
            end
        endcase
        if (toBurst || toNormal) measNext = M_IDLE;
        if (toStream) measNext = M_STREAM;
    end

    // state, lamps and arming
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            measState_q <= M_IDLE;
            contArm_q   <= 1'b0;
            armLamp_q   <= 1'b0;
            procLamp_q  <= 1'b0;
            idle_q      <= 1'b1;
            panelLock_q <= 1'b0;
        end else begin
            measState_q <= measNext;
            if (contWrite) contArm_q <= cmdFlag;
            armLamp_q   <= (measNext == M_STORE);
            procLamp_q  <= (measNext == M_PROC);
            idle_q      <= (measNext == M_IDLE);
            panelLock_q <= (measNext == M_STREAM);
        end
    end

    lamps_exclusive_a: assert property (!(armLamp_q && procLamp_q))
        else $error("storing and processing lamps lit together");
    burst_enter_idle_a: assert property ((toBurst && !deviceClear)
        |=> (measState_q == M_IDLE) ##1 !armLamp_q)
        else $error("burst select did not idle with lamp off");
    scan_starts_store_a: assert property ((measState_q == M_WAIT && scanEvent
        && !cmdValid) |=> armLamp_q && (measState_q == M_STORE))
        else $error("scan event did not start storing");
    abort_capture_a: assert property ((measState_q == M_STORE && cmdValid)
        |=> (measState_q == M_PROC) && procLamp_q)
        else $error("command during capture did not go to processing");

    // method, auto-zero and configuration
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            methodSel_q    <= METH_NORMAL;
            autoZeroEn_q   <= `AZ_RESET;
            activeConfig_q <= `CFG_RESET;
            savedConfig_q  <= `CFG_RESET;
        end else begin
            if (azWrite) autoZeroEn_q <= cmdFlag;
            if (cfgWrite) activeConfig_q <= cmdCfg;
            if (methWrite) methodSel_q <= cmdMethod;
            if (toBurst && methodSel_q != METH_BURST) begin
                savedConfig_q  <= activeConfig_q;
                activeConfig_q <= `CFG_FAST;
            end
            if (toNormal && methodSel_q == METH_BURST)
                activeConfig_q <= savedConfig_q;
            if (toStream) begin
                autoZeroEn_q   <= 1'b0;
                activeConfig_q <= activeConfig_q & `CFG_STREAM_KEEP;
            end
            if (inStream && deviceClear)
                methodSel_q <= METH_NORMAL;
        end
    end

    azero_idle_only_a: assert property (($changed(autoZeroEn_q)
        && !panelLock_q) |-> $past(measState_q) == M_IDLE)
        else $error("auto-zero changed outside idle");
    stream_ignores_a: assert property ((inStream && cmdValid && !deviceClear)
        |=> $stable(autoZeroEn_q) && $stable(methodSel_q) && panelLock_q)
        else $error("command obeyed during stream");
    burst_restore_a: assert property ((toNormal && methodSel_q == METH_BURST)
        |=> activeConfig_q == $past(savedConfig_q))
        else $error("configuration not restored after burst");

    // answers, grouping and stamp control
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            azReply_q      <= `CH_ONE;
            methodName_q   <= `NAME_NORM;
            compactGroup_q <= 1'b0;
            stampEnable_q  <= 1'b1;
        end else begin
            azReply_q <= autoZeroEn_q ? `CH_ONE : `CH_ZERO;
            unique case (methodSel_q)
                METH_NORMAL: methodName_q <= `NAME_NORM;
                METH_BURST:  methodName_q <= `NAME_BURS;
                METH_TEXT:   methodName_q <= `NAME_ASTR;
                METH_COUNT:  methodName_q <= `NAME_SSTR;
            endcase
            compactGroup_q <= (methodSel_q == METH_BURST);
            stampEnable_q  <= (methodSel_q != METH_BURST);
        end
    end

    no_stamp_burst_a: assert property ((methodSel_q == METH_BURST
        && $past(methodSel_q) == METH_BURST) |-> compactGroup_q && !stampEnable_q)
        else $error("time-stamps kept in burst");

    // buffer storing and post processing
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            storeWrite_q <= 1'b0;
            storeData_q  <= '0;
            storeCount_q <= '0;
            mathStep_q   <= 1'b0;
            mathAddr_q   <= '0;
        end else begin
            storeWrite_q <= storing && readingValid && !storeFull;
            storeData_q  <= readingCount;
            if (isIdle && measNext != M_IDLE) storeCount_q <= '0;
            else if (storing && readingValid && !storeFull)
                storeCount_q <= storeCount_q + 1'b1;
            mathStep_q <= (measState_q == M_PROC) && !procDone;
            if (measState_q != M_PROC) mathAddr_q <= '0;
            else if (!procDone) mathAddr_q <= mathAddr_q + 1'b1;
        end
    end

    proc_then_idle_a: assert property ((measState_q == M_PROC && procDone
        && !methWrite) |=> idle_q && !procLamp_q)
        else $error("processing did not return to idle");

    // stream conversion pacing, pace pulse withheld while the fifo is full
    wire [`PACE_W-1:0] pacePeriod = (methodSel_q == METH_TEXT) ?
        `PACE_W'(TEXT_PERIOD - 1) : `PACE_W'(COUNT_PERIOD - 1);
    wire paceHit = (paceCnt_q >= pacePeriod);
    always_ff @(posedge clk_sys) begin
        if (rst || !inStream) begin
            paceCnt_q   <= '0;
            convStart_q <= 1'b0;
        end else begin
            paceCnt_q   <= paceHit ? '0 : paceCnt_q + 1'b1;
            convStart_q <= paceHit && ff.inReady;
        end
    end

    pace_pulse_a: assert property (convStart_q |=> !convStart_q)
        else $error("conversion pace pulse longer than one cycle");

    // fresh readings into the fifo, one popped per talk
    wire txLoad = talkPend_q && !txBusy_q && ff.outValid && inStream;
    assign ff.inValid  = readingValid && inStream;
    assign ff.inData   = readingCount;
    assign ff.outReady = txLoad;

    // byte image of the reading under transmission
    wire               isText   = (methodSel_q == METH_TEXT);
    wire               negative = txWord_q[`RDG_W-1];
    wire [`RDG_W-1:0]  magn     = negative ? (~txWord_q + 1'b1) : txWord_q;
    wire [2:0]         lastIdx  = isText ? `IDX_TEXT_LAST : `IDX_COUNT_LAST;
    wire [`RDG_W-1:0]  decDigit;
    wire [7:0]         textByte;
    wire [7:0]         countByte;
    wire [7:0]         nextByte;
    assign decDigit  = (txIdx_q == 3'h1) ? (magn / 16'd10000) :
                       (txIdx_q == 3'h2) ? ((magn / 16'd1000) % 16'd10) :
                       (txIdx_q == 3'h3) ? ((magn / 16'd100) % 16'd10) :
                       (txIdx_q == 3'h4) ? ((magn / 16'd10) % 16'd10) : (magn % 16'd10);
    assign textByte  = (txIdx_q == 3'h0) ? (negative ? `CH_MINUS : `CH_PLUS) :
                       (txIdx_q == lastIdx) ? `CH_LF :
                       (`CH_ZERO + decDigit[7:0]);
    assign countByte = (txIdx_q == 3'h0) ? txWord_q[15:8] : txWord_q[7:0];
    assign nextByte  = isText ? textByte : countByte;

    // talk request and byte sender
    always_ff @(posedge clk_sys) begin
        if (rst || deviceClear) begin
            talkPend_q <= 1'b0;
            txBusy_q   <= 1'b0;
            txIdx_q    <= '0;
            txWord_q   <= '0;
            txValid_q  <= 1'b0;
            txByte_q   <= '0;
            txEoi_q    <= 1'b0;
        end else begin
            if (talkAddr && inStream) talkPend_q <= 1'b1;
            else if (txLoad) talkPend_q <= 1'b0;
            if (txLoad) begin
                txBusy_q <= 1'b1;
                txWord_q <= ff.outData;
                txIdx_q  <= '0;
            end else if (txBusy_q && !txValid_q) begin
                txValid_q <= 1'b1;
                txByte_q  <= nextByte;
                txEoi_q   <= (txIdx_q == lastIdx);
            end else if (txValid_q && txReady) begin
                txValid_q <= 1'b0;
                txEoi_q   <= 1'b0;
                txIdx_q   <= txIdx_q + 1'b1;
                if (txEoi_q) txBusy_q <= 1'b0;
            end
        end
    end

    count_eoi_second_a: assert property ((txValid_q && txEoi_q
        && methodSel_q == METH_COUNT) |-> txIdx_q == `IDX_COUNT_LAST)
        else $error("count end flag not on second byte");
    text_lf_eoi_a: assert property ((txValid_q && txEoi_q && isText)
        |-> txByte_q == `CH_LF)
        else $error("text end flag not with line feed");
    one_per_talk_a: assert property (txLoad |=> !talkPend_q && txBusy_q
        && !ff.outReady)
        else $error("talk did not load exactly one reading");
endmodule : acquisition_mode_control

/* File: hdl/fifo_if.sv */
// valid/ready carrier around the reading fifo
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 16);
    logic         inValid;
    logic         inReady;
    logic [W-1:0] inData;
    logic         outValid;
    logic         outReady;
    logic [W-1:0] outData;
    modport store (input inValid, inData, outReady, output inReady, outValid, outData);
    modport user  (output inValid, inData, outReady, input inReady, outValid, outData);
endinterface : fifo_if

/* File: hdl/reading_fifo.sv */
// reading fifo with parameter width and depth
`timescale 1ns/1ps
module reading_fifo #(
    parameter int DEPTH = 8
)(
    input wire logic clk_sys, // system clock
    input wire logic rst,     // sync reset
    input wire logic flush,   // drop all entries
    fifo_if.store    port     // push and pop sides
);
    localparam int AW = $clog2(DEPTH);
    logic [$bits(port.inData)-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;
    wire         full  = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    wire         empty = (wrPtr_q == rdPtr_q);
    wire         push  = port.inValid && !full;
    wire         pop   = port.outReady && !empty;
    assign port.inReady  = !full;
    assign port.outValid = !empty;
    assign port.outData  = mem[rdPtr_q[AW-1:0]];
    // storage array
    always_ff @(posedge clk_sys) begin
        if (push) mem[wrPtr_q[AW-1:0]] <= port.inData;
    end
    // pointers
    always_ff @(posedge clk_sys) begin
        if (rst || flush) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (push) wrPtr_q <= wrPtr_q + 1'b1;
            if (pop)  rdPtr_q <= rdPtr_q + 1'b1;
        end
    end
endmodule : reading_fifo

/* File: tb/acquisition_mode_control_tb.sv */
// self-checking bench for the acquisition mode controller
`timescale 1ns/1ps
module acquisition_mode_control_tb import acq_pkg::*;;
    logic        clk_sys = 1'b0, rst = 1'b1, cmdValid = 1'b0, cmdFlag = 1'b0, deviceClear = 1'b0;
    logic        scanEvent = 1'b0, readingValid = 1'b0, talkAddr = 1'b0, txReady;
    cmd_t        cmdCode = CMD_OTHER;
    method_t     cmdMethod = METH_NORMAL, methodSel_q;
    func_t       measFunc = FN_DCV;
    logic [7:0]  cmdCfg = 8'h00, azReply_q, activeConfig_q, txByte_q;
    logic [15:0] bufSize = 16'h0010, readingCount = 16'h0000, storeCount_q;
    logic [31:0] methodName_q;
    logic        autoZeroEn_q, compactGroup_q, stampEnable_q, armLamp_q, procLamp_q, idle_q;
    logic        panelLock_q, txValid_q, txEoi_q;
    logic        storeWrite_q, mathStep_q, convStart_q;
    int          errors = 0, samples_checked = 0, nWr = 0, nMath = 0, nConv = 0;
    acquisition_mode_control #(.TEXT_RATE_HZ(1000000), .COUNT_RATE_HZ(1000000)) DUT (.*,
        .storeData_q(), .mathAddr_q());
    // pulse counters for store, math and pace strobes
    always @(posedge clk_sys) begin
        nWr += storeWrite_q;
        nMath += mathStep_q;
        nConv += convStart_q;
    end
    bus_ctrl_model M (.clk_sys(clk_sys), .txValid(txValid_q), .txByte(txByte_q), .txEoi(txEoi_q), .txReady(txReady));
    // clock
    initial forever #50 clk_sys = ~clk_sys;
    task automatic conclude();
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one command strobe, then let the answers settle
    task automatic cmd(cmd_t c, logic f, method_t m);
        @(negedge clk_sys);
        {cmdValid, cmdCode, cmdFlag, cmdMethod} = {1'b1, c, f, m};
        @(negedge clk_sys);
        cmdValid = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : cmd
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask : pulse
    task automatic waitfor(ref logic s, input logic v);
        for (int k = 0; k < 2000 && s !== v; k++) @(negedge clk_sys);
        chk("wait", v, s);
    endtask : waitfor
    // expected text byte: sign, five digits, line feed with end flag
    function automatic logic [8:0] txt(logic signed [15:0] v, int i);
        int a = (v < 0) ? -int'(v) : int'(v);
        if (i == 0) return {1'b0, (v < 0) ? 8'h2D : 8'h2B};
        if (i == 6) return 9'h10A;
        return {1'b0, 8'h30 + 8'((a / (10 ** (5 - i))) % 10)};
    endfunction : txt
    // one stream session: refusal, lockout, one reading per talk, clear
    task automatic stream(method_t m, logic [15:0] v);
        int n = (m == METH_COUNT) ? 2 : 7;
        measFunc = FN_RES4;
        cmd(CMD_METHOD, 1'b0, m);
        chk("badfunc", METH_NORMAL, methodSel_q);
        measFunc = FN_RES2;
        cmd(CMD_METHOD, 1'b0, m);
        chk("lock", 1, panelLock_q);
        cmd(CMD_METHOD, 1'b0, METH_NORMAL);
        chk("ignored", m, methodSel_q);
        readingCount = v;
        pulse(readingValid);
        pulse(readingValid);
        pulse(talkAddr);
        for (int k = 0; k < 500 && M.got.size() < n; k++) @(negedge clk_sys);
        repeat (40) @(negedge clk_sys);
        chk("bytes", n, M.got.size());
        for (int i = 0; i < n && i < M.got.size(); i++) begin
            chk("byte", (m == METH_COUNT) ? {i == 1, i ? v[7:0] : v[15:8]} : txt(v, i), M.got[i]);
        end
        M.got.delete();
        pulse(deviceClear);
        chk("cleared", METH_NORMAL, methodSel_q);
        chk("unlock", 0, panelLock_q);
        chk("kept", 0, autoZeroEn_q);
    endtask : stream
    initial begin
        repeat (20000) @(negedge clk_sys);
        errors++;
        conclude();
    end
    initial begin
        void'($urandom(15409));
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("az", 1, autoZeroEn_q);
        chk("cfg", 8'hFF, activeConfig_q);
        chk("name", 32'h4E4F524D, methodName_q);
        cmd(CMD_CONT, 1'b0, METH_NORMAL);
        cmd(CMD_ABORT, 1'b0, METH_NORMAL);
        cmd(CMD_AUTOZERO, 1'b0, METH_NORMAL);
        chk("az", 0, autoZeroEn_q);
        chk("azq", 8'h30, azReply_q);
        cmd(CMD_AUTOZERO, 1'b1, METH_NORMAL);
        chk("azq", 8'h31, azReply_q);
        measFunc = FN_TEMP;
        cmd(CMD_METHOD, 1'b0, METH_BURST);
        chk("badfunc", METH_NORMAL, methodSel_q);
        measFunc = FN_ACI;
        cmd(CMD_METHOD, 1'b0, METH_BURST);
        chk("meth", METH_BURST, methodSel_q);
        chk("compact", 1, compactGroup_q);
        chk("stamp", 0, stampEnable_q);
        chk("fast", 8'h00, activeConfig_q);
        chk("arm", 0, armLamp_q);
        chk("idle", 1, idle_q);
        chk("name", 32'h42555253, methodName_q);
        cmd(CMD_INIT, 1'b0, METH_NORMAL);
        chk("waiting", 0, armLamp_q);
        pulse(scanEvent);
        chk("arm", 1, armLamp_q);
        repeat (3) begin
            readingCount = 16'($urandom);
            pulse(readingValid);
        end
        cmd(CMD_OTHER, 1'b0, METH_NORMAL);
        chk("stored", 3, storeCount_q);
        chk("writes", 3, nWr);
        waitfor(procLamp_q, 1'b0);
        repeat (5) @(negedge clk_sys);
        chk("math", 3, nMath);
        chk("idle", 1, idle_q);
        cmd(CMD_METHOD, 1'b0, METH_NORMAL);
        chk("restore", 8'hFF, activeConfig_q);
        chk("stamp", 1, stampEnable_q);
        cmd(CMD_CONT, 1'b1, METH_NORMAL);
        stream(METH_COUNT, 16'($urandom));
        stream(METH_COUNT, 16'h8000);
        stream(METH_TEXT, 16'($urandom));
        stream(METH_TEXT, 16'h0000);
        chk("pace", 1, nConv > 0);
        conclude();
    end
endmodule : acquisition_mode_control_tb

/* File: tb/bus_ctrl_model.sv */
// bus controller that takes stream bytes, stalling at random
`timescale 1ns/1ps
module bus_ctrl_model (
    input  wire logic       clk_sys, // system clock
    input  wire logic       txValid, // byte offered
    input  wire logic [7:0] txByte,  // byte value
    input  wire logic       txEoi,   // end flag
    output logic            txReady  // byte taken
);
    logic [8:0] got[$];
    initial txReady = 1'b0;
    // random stall, changed off the sampling edge
    always @(negedge clk_sys) begin
        txReady <= 1'($urandom % 2);
    end
    // keep each taken byte with its end flag
    always @(posedge clk_sys) begin
        if (txValid && txReady) begin
            got.push_back({txEoi, txByte});
        end
    end
endmodule : bus_ctrl_model
